// >>> verilog/ldc_pkg.sv
// Constants and types for the decoder configuration and speed core
package ldc_pkg;
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned RAMP_UNIT_US  = 1000;
    localparam int unsigned RAMP_UNIT_CYC = RAMP_UNIT_US * CLK_MHZ;

    localparam logic [9:0] CV_SHORT_ADDR = 10'h001;
    localparam logic [9:0] CV_START      = 10'h002;
    localparam logic [9:0] CV_ACCEL      = 10'h003;
    localparam logic [9:0] CV_DECEL      = 10'h004;
    localparam logic [9:0] CV_MAXIMUM    = 10'h005;
    localparam logic [9:0] CV_MIDDLE     = 10'h006;
    localparam logic [9:0] CV_LONG_HIGH  = 10'h011;
    localparam logic [9:0] CV_LONG_LOW   = 10'h012;
    localparam logic [9:0] CV_BRAKE_CFG  = 10'h01b;
    localparam logic [9:0] CV_BASIC_CFG  = 10'h01d;
    localparam logic [9:0] CV_TABLE_LO   = 10'h043;
    localparam logic [9:0] CV_TABLE_HI   = 10'h05e;
    localparam logic [9:0] CV_TGT_HUND   = 10'h060;
    localparam logic [9:0] CV_TGT_LOW    = 10'h061;
    localparam logic [9:0] CV_VAL_HUND   = 10'h062;
    localparam logic [9:0] CV_VAL_LOW    = 10'h063;
    localparam logic [9:0] CV_DIR_HOLD   = 10'h07c;
    localparam logic [9:0] CV_LAST       = 10'h3ff;

    localparam int unsigned BIT_LONG_ADDR = 5;
    localparam int unsigned BIT_CURVE     = 4;
    localparam int unsigned BIT_DC_BRAKE  = 3;
    localparam int unsigned BIT_DIR_HOLD  = 0;
    localparam int unsigned SHUNT_KEY     = 3;
    localparam int unsigned BYPASS_KEY    = 4;
    localparam logic        AC_SUPPORTED  = 1'b1;

    localparam logic [7:0] HUND_MAX  = 8'h09;
    localparam logic [7:0] LOW_MAX   = 8'h63;
    localparam logic [7:0] SHORT_MAX = 8'h7f;

    localparam logic [1:0] MODE_14  = 2'h0;
    localparam logic [1:0] MODE_28  = 2'h1;
    localparam logic [1:0] MODE_128 = 2'h2;

    typedef enum logic [2:0] {
        ST_DIG    = 3'h0,
        ST_DC_RUN = 3'h1,
        ST_BRAKE  = 3'h2,
        ST_BACK   = 3'h3,
        ST_AC_RUN = 3'h4,
        ST_HOLD   = 3'h5,
        ST_RETURN = 3'h6
    } ldc_state_t;

    // Value held after reset by each configuration index
    function automatic logic [7:0] cv_default(input logic [9:0] i);
        if (i >= CV_TABLE_LO && i <= CV_TABLE_HI)
            return 8'((i - CV_TABLE_LO + 10'h001) * 10'h009);
        unique case (i)
            CV_SHORT_ADDR: return 8'h03;
            CV_START:      return 8'h03;
            CV_ACCEL:      return 8'h10;
            CV_DECEL:      return 8'h0c;
            CV_MAXIMUM:    return 8'hff;
            CV_MIDDLE:     return 8'h80;
            CV_LONG_HIGH:  return 8'hc0;
            CV_LONG_LOW:   return 8'h80;
            CV_BASIC_CFG:  return 8'h0c;
            default:       return 8'h00;
        endcase
    endfunction
endpackage

// >>> verilog/ldc_ramp.sv
// Acceleration and deceleration ramp toward a target speed level
`timescale 1ns/1ps
module ldc_ramp #(
    parameter int unsigned UNIT_CYC = ldc_pkg::RAMP_UNIT_CYC
) (
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    input  wire logic [7:0] target_in,
    input  wire logic [7:0] accel_in,
    input  wire logic [7:0] decel_in,
    input  wire logic       bypass_in,
    output logic      [7:0] level_out
);
    typedef struct packed {
        logic [19:0] sub;
        logic [7:0]  units;
        logic [7:0]  level;
    } ldc_ramp_t;

    ldc_ramp_t r_reg;
    ldc_ramp_t r_next;
    logic [7:0] rate;

    assign level_out = r_reg.level;

    always_comb begin
        r_next = r_reg;
        rate = (target_in > r_reg.level) ? accel_in : decel_in;
        if (target_in == r_reg.level) begin
            r_next.sub = 20'h00000;
            r_next.units = 8'h00;
        end else if (bypass_in || rate == 8'h00) begin
            r_next.level = target_in;
        end else if (r_reg.sub != 20'(UNIT_CYC - 1)) begin
            r_next.sub = r_reg.sub + 20'h00001;
        end else begin
            r_next.sub = 20'h00000;
            // Fixed level rate per unit makes distance grow with speed
            if (r_reg.units + 8'h01 >= rate) begin
                r_next.units = 8'h00;
                r_next.level = (target_in > r_reg.level) ? r_reg.level + 8'h01
                                                         : r_reg.level - 8'h01;
            end else begin
                r_next.units = r_reg.units + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    chk_zero_rate_jump: assert property (@(posedge clock_in) disable iff (srst_in)
        (target_in > r_reg.level && accel_in == 8'h00) |=> r_reg.level == $past(target_in))
        else $error("zero acceleration did not jump to target");

    chk_single_step: assert property (@(posedge clock_in) disable iff (srst_in)
        (!bypass_in && accel_in != 8'h00 && decel_in != 8'h00) |=>
        (r_reg.level - $past(r_reg.level) <= 8'h01 || $past(r_reg.level) - r_reg.level <= 8'h01))
        else $error("ramp moved more than one level");
endmodule

// >>> verilog/ldc_core.sv
// Configuration store, address match, speed curve and sector handling
`timescale 1ns/1ps
module ldc_core #(
    parameter int unsigned RAMP_UNIT_CYC = ldc_pkg::RAMP_UNIT_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [9:0]  cfg_index_in,
    input  wire logic [7:0]  cfg_data_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_format_in,
    input  wire logic        cmd_long_in,
    input  wire logic [13:0] cmd_addr_in,
    input  wire logic        cmd_dir_in,
    input  wire logic [7:0]  cmd_step_in,
    input  wire logic [1:0]  cmd_mode_in,
    input  wire logic [4:0]  cmd_keys_in,
    input  wire logic        sector_analog_in,
    input  wire logic        sector_ac_in,
    input  wire logic        track_polarity_in,
    input  wire logic [7:0]  analog_level_in,
    output logic      [7:0]  cfg_rd_data_out,
    output logic      [7:0]  speed_level_out,
    output logic             direction_out
);
    typedef struct packed {
        logic [2:0]        s1;
        logic [2:0]        s2;
        logic [7:0]        rd;
        logic [7:0]        cstep;
        logic [1:0]        cmode;
        logic [4:0]        ckeys;
        logic              cdir;
        logic              dir;
        logic [7:0]        tgt;
        ldc_pkg::ldc_state_t st;
    } ldc_core_t;

    ldc_core_t r_reg;
    ldc_core_t r_next;
    logic [7:0] cv_mem [0:1023];

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [9:0] compose(input logic [7:0] hi,
                                           input logic [7:0] lo);
        return 10'(hi * 10'h064 + 10'(lo));
    endfunction

    // Scale a step number of the received range to 0..255
    function automatic logic [7:0] norm_step(input logic [7:0] s,
                                             input logic [1:0] m);
        logic [7:0] top;
        logic [7:0] k;
        top = 8'h7e;
        k = 8'h02;
        if (m == ldc_pkg::MODE_14) begin
            top = 8'h0e;
            k = 8'h12;
        end else if (m == ldc_pkg::MODE_28) begin
            top = 8'h1c;
            k = 8'h09;
        end
        if (s == 8'h00)
            return 8'h00;
        if (s >= top)
            return 8'hff;
        return 8'(s * k);
    endfunction

    // Two straight segments joined at the middle point
    function automatic logic [7:0] curve(input logic [7:0] n, input logic [7:0] lo,
                                         input logic [7:0] mi, input logic [7:0] hi);
        logic signed [17:0] v;
        v = 18'sh00000;
        if (n[7])
            // Offset by one so that the top step lands on the maximum exactly
            v = $signed({10'h000, mi})
                + ((($signed({10'h000, hi}) - $signed({10'h000, mi}))
                * ($signed({11'h000, n[6:0]}) + 18'sh00001)) >>> 7);
        else
            v = $signed({10'h000, lo})
                + ((($signed({10'h000, mi}) - $signed({10'h000, lo}))
                * $signed({11'h000, n[6:0]})) >>> 7);
        if (n == 8'h00 || v < 0)
            return 8'h00;
        if (v > 18'sh000ff)
            return 8'hff;
        return v[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Indirect write composition

    logic       wr_helper;
    logic [9:0] ind_tgt;
    logic [9:0] ind_val;
    logic       ind_ok;
    logic       cfg_ok;

    assign wr_helper = cfg_wr_in && cfg_index_in == ldc_pkg::CV_VAL_LOW;
    assign ind_tgt = compose(cv_mem[ldc_pkg::CV_TGT_HUND], cv_mem[ldc_pkg::CV_TGT_LOW]);
    assign ind_val = compose(cv_mem[ldc_pkg::CV_VAL_HUND], cfg_data_in);
    // Targets outside 1..1023, the helpers, or values over 255 are dropped
    assign ind_ok = cfg_data_in <= ldc_pkg::LOW_MAX
                    && ind_val <= 10'h0ff
                    && ind_tgt != 10'h000
                    && (ind_tgt < ldc_pkg::CV_TGT_HUND
                        || ind_tgt > ldc_pkg::CV_VAL_LOW);

    // Helper digit fields refuse out-of-range digits
    always_comb begin
        cfg_ok = 1'b1;
        if (cfg_index_in == ldc_pkg::CV_TGT_HUND || cfg_index_in == ldc_pkg::CV_VAL_HUND)
            cfg_ok = cfg_data_in <= ldc_pkg::HUND_MAX;
        else if (cfg_index_in == ldc_pkg::CV_TGT_LOW)
            cfg_ok = cfg_data_in <= ldc_pkg::LOW_MAX;
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            for (int i = 0; i < 1024; i++)
                cv_mem[i] <= ldc_pkg::cv_default(10'(i));
        end else if (wr_helper) begin
            // The station must have loaded 96..98 before this write
            if (ind_ok)
                cv_mem[ind_tgt] <= ind_val[7:0];
            cv_mem[ldc_pkg::CV_TGT_HUND] <= 8'h00;
            cv_mem[ldc_pkg::CV_TGT_LOW] <= 8'h00;
            cv_mem[ldc_pkg::CV_VAL_HUND] <= 8'h00;
            cv_mem[ldc_pkg::CV_VAL_LOW] <= 8'h00;
        end else if (cfg_wr_in && cfg_ok) begin
            cv_mem[cfg_index_in] <= cfg_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address match and speed shaping

    logic        long_mode;
    logic [13:0] long_addr;
    logic        match;
    logic        dchg;
    logic [7:0]  norm;
    logic [7:0]  dig_spd;
    logic [4:0]  tidx;
    logic [7:0]  ramp_level;

    assign long_mode = cv_mem[ldc_pkg::CV_BASIC_CFG][ldc_pkg::BIT_LONG_ADDR];
    assign long_addr = {cv_mem[ldc_pkg::CV_LONG_HIGH][5:0], cv_mem[ldc_pkg::CV_LONG_LOW]};

    always_comb begin
        match = 1'b0;
        if (cmd_format_in)
            match = !cmd_long_in && cmd_addr_in[7:0] == cv_mem[ldc_pkg::CV_SHORT_ADDR]
                    && cmd_addr_in[13:8] == 6'h00;
        else if (long_mode)
            match = cmd_long_in && cmd_addr_in == long_addr;
        else
            match = !cmd_long_in && cmd_addr_in[7:0] == cv_mem[ldc_pkg::CV_SHORT_ADDR]
                    && cmd_addr_in[13:8] == 6'h00
                    && cmd_addr_in[7:0] <= ldc_pkg::SHORT_MAX;
        match = match && cmd_valid_in && cmd_addr_in != 14'h0000;
    end

    assign dchg = match && cmd_dir_in != r_reg.cdir;
    assign norm = norm_step(r_reg.cstep, r_reg.cmode);
    assign tidx = 5'(({8'h00, norm} * 16'h001c) >> 8);

    always_comb begin
        if (cv_mem[ldc_pkg::CV_BASIC_CFG][ldc_pkg::BIT_CURVE])
            dig_spd = (norm == 8'h00) ? 8'h00
                      : cv_mem[ldc_pkg::CV_TABLE_LO + 10'(tidx)];
        else
            dig_spd = curve(norm, cv_mem[ldc_pkg::CV_START],
                            cv_mem[ldc_pkg::CV_MIDDLE],
                            cv_mem[ldc_pkg::CV_MAXIMUM]);
        if (r_reg.ckeys[ldc_pkg::SHUNT_KEY])
            dig_spd = {1'b0, dig_spd[7:1]};
    end

    ////////////////////////////////////////////////////////////////////////
    // Sector state machine

    logic ana;
    logic ac;
    logic pol;
    logic brake_en;
    logic hold_en;

    assign ana = r_reg.s2[1];
    assign ac = r_reg.s2[2];
    assign pol = r_reg.s2[0];
    assign brake_en = cv_mem[ldc_pkg::CV_BRAKE_CFG][ldc_pkg::BIT_DC_BRAKE];
    assign hold_en = cv_mem[ldc_pkg::CV_DIR_HOLD][ldc_pkg::BIT_DIR_HOLD];

    always_comb begin
        r_next = r_reg;
        r_next.s1 = {sector_ac_in, sector_analog_in, track_polarity_in};
        r_next.s2 = r_reg.s1;
        if (cfg_rd_in)
            r_next.rd = cv_mem[cfg_index_in];
        if (match) begin
            r_next.cstep = cmd_step_in;
            r_next.cmode = cmd_mode_in;
            r_next.ckeys = cmd_keys_in;
            r_next.cdir = cmd_dir_in;
        end
        r_next.tgt = dig_spd;
        unique case (r_reg.st)
            ldc_pkg::ST_DIG: begin
                r_next.dir = r_reg.cdir;
                if (ana && ac) begin
                    // Variant without AC running stops instead
                    r_next.st = ldc_pkg::AC_SUPPORTED ? ldc_pkg::ST_AC_RUN
                                                      : ldc_pkg::ST_BRAKE;
                end else if (ana && pol == r_reg.dir) begin
                    r_next.st = ldc_pkg::ST_DC_RUN;
                end else if (ana && brake_en) begin
                    r_next.st = ldc_pkg::ST_BRAKE;
                end else if (ana) begin
                    r_next.st = ldc_pkg::ST_BACK;
                    r_next.dir = !r_reg.dir;
                end
            end
            ldc_pkg::ST_DC_RUN, ldc_pkg::ST_AC_RUN, ldc_pkg::ST_BACK: begin
                r_next.tgt = analog_level_in;
            end
            ldc_pkg::ST_BRAKE: begin
                r_next.tgt = 8'h00;
            end
            ldc_pkg::ST_RETURN: begin
                r_next.tgt = 8'h00;
                if (ramp_level == 8'h00) begin
                    r_next.dir = !r_reg.dir;
                    r_next.st = ldc_pkg::ST_HOLD;
                end
            end
            ldc_pkg::ST_HOLD: begin
                if (dchg)
                    r_next.st = ldc_pkg::ST_DIG;
            end
            default: r_next.st = ldc_pkg::ST_DIG;
        endcase
        // Leaving any analogue state on return of the digital signal
        if (!ana && (r_reg.st == ldc_pkg::ST_DC_RUN || r_reg.st == ldc_pkg::ST_AC_RUN
                     || r_reg.st == ldc_pkg::ST_BACK || r_reg.st == ldc_pkg::ST_BRAKE)) begin
            if (r_reg.dir == r_reg.cdir)
                r_next.st = ldc_pkg::ST_DIG;
            else if (hold_en)
                r_next.st = ldc_pkg::ST_HOLD;
            else
                r_next.st = ldc_pkg::ST_RETURN;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            r_reg <= '0;
            r_reg.dir <= 1'b1;
            r_reg.cdir <= 1'b1;
            r_reg.st <= ldc_pkg::ST_DIG;
        end else begin
            r_reg <= r_next;
        end
    end

    ldc_ramp #(
        .UNIT_CYC (RAMP_UNIT_CYC)
    ) u_ramp (
        .clock_in  (clock_in),
        .srst_in   (srst_in),
        .target_in (r_reg.tgt),
        .accel_in  (cv_mem[ldc_pkg::CV_ACCEL]),
        .decel_in  (cv_mem[ldc_pkg::CV_DECEL]),
        .bypass_in (r_reg.ckeys[ldc_pkg::BYPASS_KEY]),
        .level_out (ramp_level)
    );

    assign cfg_rd_data_out = r_reg.rd;
    assign speed_level_out = ramp_level;
    assign direction_out = r_reg.dir;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    sequence s_dc_bad;
        r_reg.st == ldc_pkg::ST_DIG && ana && !ac && pol != r_reg.dir;
    endsequence

    chk_helper_clear: assert property (
        wr_helper |=> cv_mem[ldc_pkg::CV_TGT_HUND] == 8'h00
                      && cv_mem[ldc_pkg::CV_VAL_LOW] == 8'h00)
        else $error("helpers not cleared after indirect write");

    chk_indirect_store: assert property (
        (wr_helper && ind_ok) |=> cv_mem[$past(ind_tgt)] == $past(ind_val[7:0]))
        else $error("indirect value not stored at target");

    chk_hundreds_range: assert property (
        (cfg_wr_in && cfg_index_in == ldc_pkg::CV_TGT_HUND
         && cfg_data_in > ldc_pkg::HUND_MAX) |=> $stable(cv_mem[ldc_pkg::CV_TGT_HUND]))
        else $error("out of range hundreds digit accepted");

    chk_short_only: assert property (
        (cmd_valid_in && !cmd_format_in && !cmd_long_in && long_mode
         && cmd_step_in != r_reg.cstep) |=> $stable(r_reg.cstep))
        else $error("short address answered in long mode");

    chk_dc_brake: assert property (
        (s_dc_bad and brake_en) |=> r_reg.st == ldc_pkg::ST_BRAKE ##1 r_reg.tgt == 8'h00)
        else $error("mismatched DC entry did not brake");

    chk_hold_dir: assert property (
        (r_reg.st == ldc_pkg::ST_HOLD && r_next.st == ldc_pkg::ST_HOLD)
        |=> direction_out == $past(direction_out))
        else $error("direction changed while held");
endmodule

// >>> verif/ldc_station.sv
// Command station model: config access, speed packets and track sectors
`timescale 1ns/1ps
module ldc_station (
    input  wire logic        clock_in,
    input  wire logic [7:0]  rd_data_in,
    output logic             cfg_wr_out,
    output logic             cfg_rd_out,
    output logic [9:0]       cfg_index_out,
    output logic [7:0]       cfg_data_out,
    output logic             cmd_valid_out,
    output logic             cmd_format_out,
    output logic             cmd_long_out,
    output logic [13:0]      cmd_addr_out,
    output logic             cmd_dir_out,
    output logic [7:0]       cmd_step_out,
    output logic [1:0]       cmd_mode_out,
    output logic [4:0]       cmd_keys_out,
    output logic             analog_out,
    output logic             ac_out,
    output logic             polarity_out,
    output logic [7:0]       level_out
);
    initial begin
        {cfg_wr_out, cfg_rd_out, cfg_index_out, cfg_data_out} = '0;
        {cmd_valid_out, cmd_format_out, cmd_long_out, cmd_addr_out} = '0;
        {cmd_dir_out, cmd_step_out, cmd_mode_out, cmd_keys_out} = '0;
        {analog_out, ac_out, polarity_out, level_out} = '0;
    end
    task automatic cfg_write(input logic [9:0] idx, input logic [7:0] d);
        @(posedge clock_in);
        cfg_wr_out    <= 1'b1;
        cfg_index_out <= idx;
        cfg_data_out  <= d;
        @(posedge clock_in);
        cfg_wr_out    <= 1'b0;
    endtask
    task automatic cfg_read(input logic [9:0] idx, output logic [7:0] d);
        @(posedge clock_in);
        cfg_rd_out    <= 1'b1;
        cfg_index_out <= idx;
        @(posedge clock_in);
        cfg_rd_out    <= 1'b0;
        @(posedge clock_in);
        #1;
        d = rd_data_in;
    endtask
    // Value register last, as its write launches the transfer
    task automatic ind_write(input logic [9:0] t, input logic [7:0] v);
        cfg_write(10'h060, 8'(t / 100));
        cfg_write(10'h061, 8'(t % 100));
        cfg_write(10'h062, 8'(v / 100));
        cfg_write(10'h063, 8'(v % 100));
    endtask
    task automatic packet(input logic f, input logic l, input logic [13:0] a,
                          input logic [7:0] s, input logic [1:0] m, input logic [4:0] k);
        packet_dir(1'b1, f, l, a, s, m, k);
    endtask
    task automatic packet_dir(input logic dr, input logic f, input logic l,
                              input logic [13:0] a, input logic [7:0] s,
                              input logic [1:0] m, input logic [4:0] k);
        @(posedge clock_in);
        {cmd_valid_out, cmd_format_out, cmd_long_out, cmd_addr_out} <= {1'b1, f, l, a};
        {cmd_dir_out, cmd_step_out, cmd_mode_out, cmd_keys_out} <= {dr, s, m, k};
        @(posedge clock_in);
        cmd_valid_out <= 1'b0;
    endtask
    task automatic track(input logic an, input logic ac, input logic p, input logic [7:0] v);
        @(posedge clock_in);
        {analog_out, ac_out, polarity_out, level_out} <= {an, ac, p, v};
    endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the decoder configuration and speed core
`timescale 1ns/1ps
module tb;
    logic        clock_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        wr, rd, vld, fmt, lng, dir, an, ac, pol;
    logic [9:0]  idx;
    logic [7:0]  dat, step, lvl, rdd, spd, m, a, d;
    logic [13:0] adr;
    logic [1:0]  mode;
    logic [4:0]  keys;
    logic        dir_o;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    always #5 clock_in = ~clock_in;
    ldc_station st (.clock_in(clock_in), .rd_data_in(rdd), .cfg_wr_out(wr), .cfg_rd_out(rd),
        .cfg_index_out(idx), .cfg_data_out(dat), .cmd_valid_out(vld), .cmd_format_out(fmt),
        .cmd_long_out(lng), .cmd_addr_out(adr), .cmd_dir_out(dir), .cmd_step_out(step),
        .cmd_mode_out(mode), .cmd_keys_out(keys), .analog_out(an), .ac_out(ac),
        .polarity_out(pol), .level_out(lvl));
    ldc_core #(.RAMP_UNIT_CYC(4)) uut (.clock_in(clock_in), .srst_in(srst_in),
        .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_index_in(idx), .cfg_data_in(dat),
        .cmd_valid_in(vld), .cmd_format_in(fmt), .cmd_long_in(lng), .cmd_addr_in(adr),
        .cmd_dir_in(dir), .cmd_step_in(step), .cmd_mode_in(mode), .cmd_keys_in(keys),
        .sector_analog_in(an), .sector_ac_in(ac), .track_polarity_in(pol),
        .analog_level_in(lvl), .cfg_rd_data_out(rdd), .speed_level_out(spd),
        .direction_out(dir_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_chk(input string name, input logic [9:0] i, input logic [7:0] exp);
        logic [7:0] v;
        st.cfg_read(i, v);
        check(name, v, exp);
    endtask
    // Bounded wait on speed (sel 0) or direction (sel 1)
    task automatic wait_for(input string name, input logic sel, input logic [7:0] exp);
        logic [7:0] v;
        for (int i = 0; i < 200; i++) begin
            @(posedge clock_in);
            #1;
            v = sel ? {7'h00, dir_o} : spd;
            if (v === exp)
                break;
        end
        check(name, v, exp);
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [9:0] t;
        void'($urandom(43293));
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        rd_chk("short_addr", 10'h001, 8'h03);
        rd_chk("unmapped", 10'h0c8, 8'h00);
        st.cfg_write(10'h060, 8'h0a);
        rd_chk("tgt_hund", 10'h060, 8'h00);
        st.cfg_write(10'h061, 8'h64);
        rd_chk("tgt_low", 10'h061, 8'h00);
        st.cfg_write(10'h062, 8'h05);
        rd_chk("val_hund", 10'h062, 8'h05);
        st.ind_write(10'd317, 8'd120);
        rd_chk("indirect", 10'd317, 8'd120);
        for (int i = 96; i < 100; i++)
            rd_chk("helper", 10'(i), 8'h00);
        for (int i = 0; i < 6; i++) begin
            t = 10'(100 + $urandom % 900);
            if (t == 10'd124)
                t = 10'd125;
            d = 8'($urandom);
            st.ind_write(t, d);
            rd_chk("indirect_rnd", t, d);
        end
        st.ind_write(10'd97, 8'd55);
        rd_chk("discard", 10'd97, 8'h00);
        // Value 256 does not fit a level and must be dropped
        st.cfg_write(10'h060, 8'h00);
        st.cfg_write(10'h061, 8'h32);
        st.cfg_write(10'h062, 8'h02);
        st.cfg_write(10'h063, 8'h38);
        rd_chk("discard_val", 10'h032, 8'h00);
        rd_chk("helper_val", 10'h062, 8'h00);
        // Momentum off so that levels settle at once
        st.cfg_write(10'h003, 8'h00);
        st.cfg_write(10'h004, 8'h00);
        // Middle level 0x80 must stay below the maximum
        m = 8'h81 + 8'($urandom % 127);
        st.cfg_write(10'h005, m);
        for (int k = 0; k < 3; k++) begin
            st.packet(1'b0, 1'b0, 14'd3, (k == 0) ? 8'd14 : (k == 1) ? 8'd28 : 8'd126,
                      2'(k), 5'h00);
            wait_for("top_step", 1'b0, m);
            st.packet(1'b0, 1'b0, 14'd3, 8'd0, 2'(k), 5'h00);
            wait_for("stop", 1'b0, 8'h00);
        end
        st.packet(1'b0, 1'b0, 14'd4, 8'd126, 2'h2, 5'h00);
        repeat (12) @(posedge clock_in);
        check("foreign", spd, 8'h00);
        st.cfg_write(10'h01d, 8'h2c);
        st.packet(1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h00);
        repeat (12) @(posedge clock_in);
        check("short_off", spd, 8'h00);
        st.packet(1'b0, 1'b1, 14'd128, 8'd126, 2'h2, 5'h00);
        wait_for("long", 1'b0, m);
        st.packet(1'b1, 1'b0, 14'd3, 8'd0, 2'h2, 5'h00);
        wait_for("second_fmt", 1'b0, 8'h00);
        a = 8'($urandom);
        st.cfg_write(10'h05e, a);
        st.cfg_write(10'h01d, 8'h3c);
        st.packet(1'b0, 1'b1, 14'd128, 8'd126, 2'h2, 5'h00);
        wait_for("table", 1'b0, a);
        st.cfg_write(10'h01d, 8'h0c);
        st.packet(1'b0, 1'b0, 14'd3, 8'd0, 2'h2, 5'h00);
        wait_for("stop2", 1'b0, 8'h00);
        // Slow ramp: one level per eight cycles
        st.cfg_write(10'h003, 8'h02);
        st.packet(1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h00);
        repeat (30) @(posedge clock_in);
        check("ramp", 8'(spd > 0 && spd < 8), 8'h01);
        st.packet(1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h10);
        wait_for("bypass", 1'b0, m);
        st.cfg_write(10'h003, 8'h00);
        st.packet(1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h08);
        repeat (12) @(posedge clock_in);
        check("shunt", 8'(spd < m && spd > 0), 8'h01);
        st.packet(1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h00);
        wait_for("resume", 1'b0, m);
        a = 8'($urandom % 255) + 8'h01;
        st.track(1'b1, 1'b0, 1'b1, a);
        wait_for("dc_match", 1'b0, a);
        st.track(1'b0, 1'b0, 1'b0, 8'h00);
        wait_for("digital", 1'b0, m);
        st.cfg_write(10'h01b, 8'h08);
        st.track(1'b1, 1'b0, 1'b0, a);
        wait_for("dc_brake", 1'b0, 8'h00);
        wait_for("brake_dir", 1'b1, 8'h01);
        st.track(1'b0, 1'b0, 1'b0, 8'h00);
        wait_for("digital2", 1'b0, m);
        st.track(1'b1, 1'b1, 1'b0, a);
        wait_for("ac_run", 1'b0, a);
        wait_for("ac_dir", 1'b1, 8'h01);
        st.track(1'b0, 1'b0, 1'b0, 8'h00);
        wait_for("digital3", 1'b0, m);
        st.cfg_write(10'h01b, 8'h00);
        st.track(1'b1, 1'b0, 1'b0, a);
        wait_for("dc_reverse", 1'b1, 8'h00);
        // Leaving while reversed without hold: stop, then turn round
        st.track(1'b0, 1'b0, 1'b0, 8'h00);
        wait_for("ret_stop", 1'b0, 8'h00);
        wait_for("ret_dir", 1'b1, 8'h01);
        st.cfg_write(10'h07c, 8'h01);
        st.packet_dir(1'b0, 1'b0, 1'b0, 14'd3, 8'd126, 2'h2, 5'h00);
        wait_for("dir_change", 1'b1, 8'h00);
        st.track(1'b1, 1'b0, 1'b1, a);
        wait_for("back2", 1'b1, 8'h01);
        st.track(1'b0, 1'b0, 1'b0, 8'h00);
        wait_for("hold_spd", 1'b0, m);
        st.packet_dir(1'b0, 1'b0, 1'b0, 14'd3, 8'd0, 2'h2, 5'h00);
        wait_for("hold_stop", 1'b0, 8'h00);
        wait_for("hold_dir", 1'b1, 8'h01);
        tally_and_finish();
    end
endmodule
